// ===== src/tcc_timer.sv
// 16-bit timer with three compare channels behind an AHB-Lite slave
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module tcc_timer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        evt_a,
  output logic [2:0]       channel_waveform_output,
  output logic [2:0]       channel_output_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned NCH = tcc_pkg::TCC_NCH;

  logic        ready_ff;
  logic [31:0] rdata_ff;
  logic        resp_ff;
  logic [7:0]  addr_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;

  logic [3:0]  control_word_a_ff;
  logic [6:0]  control_word_b_ff;
  logic [1:0]  control_word_e_ff;
  logic        event_control_register_ff;
  logic [15:0] count_register_ff;
  logic [15:0] cycle_length_ff;
  logic [15:0] cycle_length_shadow_ff;
  logic        cycle_length_shadow_valid_ff;
  logic [15:0] match_value_ff [NCH];
  logic [15:0] match_shadow_ff [NCH];
  logic [NCH-1:0] match_shadow_valid_ff;
  logic        ovf_flag_ff;
  logic [NCH-1:0] match_flag_ff;
  logic [NCH-1:0] wo_ff;
  logic [NCH-1:0] wo_oe_ff;

  logic        evt_s1_ff;
  logic        evt_s2_ff;
  logic        evt_s3_ff;

  logic        addr_take;
  logic        run;
  logic        count_down;
  logic        update_lock;
  logic        event_count_input_enable;
  logic [2:0]  tick_divider_select;
  logic [2:0]  channel_output_enable_n;
  tcc_pkg::tcc_wg_t waveform_mode_field;
  logic        wave_mode_on;
  logic        pre_tick;
  logic        evt_edge;
  logic        step;
  logic [15:0] top;
  logic        at_top;
  logic        at_bottom;
  logic        wrap;
  logic        do_update;
  logic [15:0] nxt_count;
  logic [31:0] nxt_rdata;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] wave;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign hreadyout = ready_ff;
  assign hrdata = rdata_ff;
  assign hresp = resp_ff;
  assign addr_take = hsel && htrans[1] && hready;

  // writes finish without wait; reads add one wait state so the
  // returned word sees any write of the transfer just before it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_ff <= 8'h00;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else if (ce) begin
      if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        ready_ff <= 1'b1;
        wr_pend_ff <= 1'b0;
      end else begin
        wr_pend_ff <= addr_take && hwrite;
        rd_pend_ff <= addr_take && !hwrite;
        ready_ff <= !(addr_take && !hwrite);
        if (addr_take) begin
          addr_ff <= haddr[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_ff <= 1'b0;
    end else if (ce) begin
      resp_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (addr_ff)
      tcc_pkg::TCC_OFF_CTRL_A: nxt_rdata[3:0] = control_word_a_ff;
      tcc_pkg::TCC_OFF_CTRL_B: nxt_rdata[6:0] = control_word_b_ff;
      tcc_pkg::TCC_OFF_CTRL_E: nxt_rdata[1:0] = control_word_e_ff;
      tcc_pkg::TCC_OFF_CTRL_F: nxt_rdata[3:0] = {match_shadow_valid_ff,
                                                 cycle_length_shadow_valid_ff}; // R08
      tcc_pkg::TCC_OFF_EVENT_CONTROL_REGISTER: nxt_rdata[0] = event_control_register_ff;
      tcc_pkg::TCC_OFF_FLAGS: nxt_rdata[6:0] = {match_flag_ff, 3'h0, ovf_flag_ff};
      tcc_pkg::TCC_OFF_COUNT: nxt_rdata[15:0] = count_register_ff;
      tcc_pkg::TCC_OFF_PERIOD: nxt_rdata[15:0] = cycle_length_ff;
      tcc_pkg::TCC_OFF_PER_SH: nxt_rdata[15:0] = cycle_length_shadow_ff;
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (addr_ff == tcc_pkg::TCC_OFF_MATCH0 + 8'(i) * tcc_pkg::TCC_OFF_STEP) begin
            nxt_rdata[15:0] = match_value_ff[i]; // R10
          end
          if (addr_ff == tcc_pkg::TCC_OFF_MSH0 + 8'(i) * tcc_pkg::TCC_OFF_STEP) begin
            nxt_rdata[15:0] = match_shadow_ff[i]; // R10
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce && rd_pend_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_word_a_ff <= 4'h0;
      control_word_b_ff <= 7'h00;
      control_word_e_ff <= 2'h0;
      event_control_register_ff <= 1'b0;
    end else if (ce && wr_pend_ff) begin
      if (addr_ff == tcc_pkg::TCC_OFF_CTRL_A) begin
        control_word_a_ff <= hwdata[3:0]; // R01
      end
      if (addr_ff == tcc_pkg::TCC_OFF_CTRL_B) begin
        control_word_b_ff <= hwdata[6:0];
      end
      if (addr_ff == tcc_pkg::TCC_OFF_CTRL_E) begin
        control_word_e_ff <= hwdata[1:0]; // R07
      end
      if (addr_ff == tcc_pkg::TCC_OFF_EVENT_CONTROL_REGISTER) begin
        event_control_register_ff <= hwdata[0]; // R02
      end
    end
  end

  assign run = control_word_a_ff[tcc_pkg::TCC_A_RUN];
  assign tick_divider_select = control_word_a_ff[tcc_pkg::TCC_A_SEL +: 3];
  assign waveform_mode_field = tcc_pkg::tcc_wg_t'(control_word_b_ff[tcc_pkg::TCC_B_MODE +: 3]);
  assign channel_output_enable_n = control_word_b_ff[tcc_pkg::TCC_B_EN +: 3];
  assign count_down = control_word_e_ff[tcc_pkg::TCC_E_DOWN];
  assign update_lock = control_word_e_ff[tcc_pkg::TCC_E_LOCK];
  assign event_count_input_enable = event_control_register_ff;
  assign wave_mode_on = (waveform_mode_field == tcc_pkg::TCC_WG_TOGGLE)
                     || (waveform_mode_field == tcc_pkg::TCC_WG_SINGLE);

  // ----------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------
  tcc_prescaler u_pre (
    .clk  (clk),
    .rst_n(rst_n),
    .ce   (ce),
    .run  (run),
    .sel  (tick_divider_select),
    .tick (pre_tick)
  );

  // event pin is asynchronous: two stages, then edge detect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_s1_ff <= 1'b0;
      evt_s2_ff <= 1'b0;
      evt_s3_ff <= 1'b0;
    end else if (ce) begin
      evt_s1_ff <= evt_a;
      evt_s2_ff <= evt_s1_ff;
      evt_s3_ff <= evt_s2_ff;
    end
  end

  assign evt_edge = evt_s2_ff && !evt_s3_ff;
  assign step = run && (event_count_input_enable ? evt_edge : pre_tick); // R01 R02 R03

  // ----------------------------------------------------------------
  // base counter
  // ----------------------------------------------------------------
  // toggle mode takes its period from match register zero
  assign top = (waveform_mode_field == tcc_pkg::TCC_WG_TOGGLE) ? match_value_ff[0]
                                                              : cycle_length_ff; // R19
  // equality only, so a top below the count runs on to all ones first
  assign at_top = (count_register_ff == top); // R11 R12
  assign at_bottom = (count_register_ff == tcc_pkg::TCC_RST_ZERO);
  assign wrap = step && (count_down ? at_bottom : at_top);
  assign do_update = wrap && !update_lock; // R23

  always_comb begin
    if (count_down) begin
      nxt_count = at_bottom ? top : count_register_ff - 16'h0001; // R05
    end else begin
      nxt_count = at_top ? tcc_pkg::TCC_RST_ZERO : count_register_ff + 16'h0001; // R04
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_register_ff <= tcc_pkg::TCC_RST_ZERO;
    end else if (ce) begin
      if (wr_pend_ff && addr_ff == tcc_pkg::TCC_OFF_COUNT) begin
        count_register_ff <= hwdata[15:0]; // R06
      end else if (step) begin
        count_register_ff <= nxt_count; // R03 R07
      end
    end
  end

  // ----------------------------------------------------------------
  // period and its shadow
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycle_length_ff <= tcc_pkg::TCC_RST_PERIOD;
    end else if (ce) begin
      if (wr_pend_ff && addr_ff == tcc_pkg::TCC_OFF_PERIOD) begin
        cycle_length_ff <= hwdata[15:0]; // R10 R11
      end else if (do_update && cycle_length_shadow_valid_ff) begin
        cycle_length_ff <= cycle_length_shadow_ff; // R13
      end
    end
  end

  // a shadow write in the update cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycle_length_shadow_ff <= tcc_pkg::TCC_RST_ZERO;
      cycle_length_shadow_valid_ff <= 1'b0;
    end else if (ce) begin
      if (wr_pend_ff && addr_ff == tcc_pkg::TCC_OFF_PER_SH) begin
        cycle_length_shadow_ff <= hwdata[15:0];
        cycle_length_shadow_valid_ff <= 1'b1; // R08 R09
      end else if (do_update) begin
        cycle_length_shadow_valid_ff <= 1'b0; // R09
      end
    end
  end

  // ----------------------------------------------------------------
  // match registers and channels
  // ----------------------------------------------------------------
  tcc_chan_if ch_if [NCH] ();

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    localparam logic [7:0] ACT_OFF = tcc_pkg::TCC_OFF_MATCH0 + 8'(g) * tcc_pkg::TCC_OFF_STEP;
    localparam logic [7:0] SH_OFF = tcc_pkg::TCC_OFF_MSH0 + 8'(g) * tcc_pkg::TCC_OFF_STEP;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        match_value_ff[g] <= tcc_pkg::TCC_RST_ZERO;
      end else if (ce) begin
        if (wr_pend_ff && addr_ff == ACT_OFF) begin
          match_value_ff[g] <= hwdata[15:0]; // R10
        end else if (do_update && match_shadow_valid_ff[g]) begin
          match_value_ff[g] <= match_shadow_ff[g]; // R15
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        match_shadow_ff[g] <= tcc_pkg::TCC_RST_ZERO;
        match_shadow_valid_ff[g] <= 1'b0;
      end else if (ce) begin
        if (wr_pend_ff && addr_ff == SH_OFF) begin
          match_shadow_ff[g] <= hwdata[15:0];
          match_shadow_valid_ff[g] <= 1'b1; // R08 R09
        end else if (do_update) begin
          match_shadow_valid_ff[g] <= 1'b0; // R09
        end
      end
    end

    assign ch_if[g].step = step;
    assign ch_if[g].cnt = count_register_ff;
    assign ch_if[g].match_val = match_value_ff[g];
    assign ch_if[g].mode = waveform_mode_field;
    assign hit[g] = ch_if[g].hit;
    assign wave[g] = ch_if[g].wave;

    tcc_channel u_ch (
      .clk  (clk),
      .rst_n(rst_n),
      .ce   (ce),
      .ch   (ch_if[g])
    );

    // pin override: one more register so the output is a flop here
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        wo_ff[g] <= 1'b0;
        wo_oe_ff[g] <= 1'b0;
      end else if (ce) begin
        wo_ff[g] <= wave_mode_on && channel_output_enable_n[g] && wave[g]; // R16 R18
        wo_oe_ff[g] <= wave_mode_on && channel_output_enable_n[g]; // R16 R17
      end
    end
  end

  assign channel_waveform_output = wo_ff;
  assign channel_output_oe = wo_oe_ff;

  // ----------------------------------------------------------------
  // status flags: write one to clear, a new event wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_flag_ff <= 1'b0;
      match_flag_ff <= 3'h0;
    end else if (ce) begin
      if (wrap) begin
        ovf_flag_ff <= 1'b1; // R24 R25
      end else if (wr_pend_ff && addr_ff == tcc_pkg::TCC_OFF_FLAGS
                   && hwdata[tcc_pkg::TCC_FL_OVF]) begin
        ovf_flag_ff <= 1'b0;
      end
      for (int i = 0; i < NCH; i++) begin
        if (hit[i]) begin
          match_flag_ff[i] <= 1'b1; // R14 R24
        end else if (wr_pend_ff && addr_ff == tcc_pkg::TCC_OFF_FLAGS
                     && hwdata[tcc_pkg::TCC_FL_MATCH + i]) begin
          match_flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  // hsize is not checked: only whole-word transfers are supported
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8], hwdata[31:16]};

endmodule

// ===== common/tcc_pkg.sv
// constants, field layout and types of the compare/waveform timer
//
// Functional notes
// [R01] software loads top then sets run bit
// [R02] event count bit selects event input ticks
// [R03] counter steps per tick in selected direction
// [R04] counting up, top wraps to zero
// [R05] counting down, zero reloads cycle length
// [R06] count register write beats any count action
// [R07] direction may change while running
// [R08] period and matches have shadow plus valid flag
// [R09] valid set on shadow write, cleared on update
// [R10] active and shadow both reachable; active write immediate
// [R11] unbuffered period write takes effect at once
// [R12] top below count: run full range first
// [R13] buffered period changes only at update
// [R14] match sets channel flag one tick later
// [R15] valid match shadows copied at update
// [R16] override needs waveform mode and channel enable
// [R17] port logic outside sets pin direction
// [R18] only three waveform outputs in this mode
// [R19] toggle mode: match zero sets period, outputs toggle
// [R20] toggle with match zero gives half clock
// [R21] single slope: high at zero, low on match
// [R22] match zero low; match above top high
// [R23] update at wrap, suppressed by update lock
// [R24] trigger effects appear on following tick cycle
// [R25] overflow flag on wrap or reload
package tcc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned TCC_CW = 16;
  localparam int unsigned TCC_NCH = 3;
  localparam int unsigned TCC_PW = 10;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] TCC_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] TCC_OFF_CTRL_E = 8'h08;
  localparam logic [7:0] TCC_OFF_CTRL_F = 8'h0c;
  localparam logic [7:0] TCC_OFF_EVENT_CONTROL_REGISTER = 8'h10;
  localparam logic [7:0] TCC_OFF_FLAGS = 8'h14;
  localparam logic [7:0] TCC_OFF_COUNT = 8'h18;
  localparam logic [7:0] TCC_OFF_PERIOD = 8'h1c;
  localparam logic [7:0] TCC_OFF_MATCH0 = 8'h20;
  localparam logic [7:0] TCC_OFF_PER_SH = 8'h2c;
  localparam logic [7:0] TCC_OFF_MSH0 = 8'h30;
  localparam logic [7:0] TCC_OFF_STEP = 8'h04;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned TCC_A_RUN = 0;
  localparam int unsigned TCC_A_SEL = 1;
  localparam int unsigned TCC_B_MODE = 0;
  localparam int unsigned TCC_B_EN = 4;
  localparam int unsigned TCC_E_DOWN = 0;
  localparam int unsigned TCC_E_LOCK = 1;
  localparam int unsigned TCC_F_PER_BV = 0;
  localparam int unsigned TCC_F_MSH_BV = 1;
  localparam int unsigned TCC_EV_EVENT_COUNT_INPUT_ENABLE = 0;
  localparam int unsigned TCC_FL_OVF = 0;
  localparam int unsigned TCC_FL_MATCH = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TCC_RST_ZERO = 16'h0000;
  localparam logic [15:0] TCC_RST_PERIOD = 16'hffff;

  // prescaler masks: tick when the low bits of the divider are all ones
  localparam logic [7:0][9:0] TCC_DIV_MASK = {10'h3ff, 10'h0ff, 10'h03f, 10'h00f,
                                             10'h007, 10'h003, 10'h001, 10'h000};

  typedef enum logic [2:0] {
    TCC_WG_NORMAL = 3'b000,
    TCC_WG_TOGGLE = 3'b001,
    TCC_WG_SINGLE = 3'b011
  } tcc_wg_t;

endpackage

// ===== common/tcc_chan_if.sv
// signals between the counter core and one compare channel
`timescale 1ns/10ps
interface tcc_chan_if;
  logic                 step;
  logic [15:0]          cnt;
  logic [15:0]          match_val;
  tcc_pkg::tcc_wg_t     mode;
  logic                 hit;
  logic                 wave;

  modport core (output step, output cnt, output match_val, output mode,
                input hit, input wave);
  modport chan (input step, input cnt, input match_val, input mode,
                output hit, output wave);
endinterface

// ===== src/tcc_prescaler.sv
// divides the peripheral clock into count ticks
`timescale 1ns/10ps
module tcc_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [9:0] div_ff;
  logic [9:0] mask;

  assign mask = tcc_pkg::TCC_DIV_MASK[sel];
  assign tick = run && ((div_ff & mask) == mask); // R01

  // divider restarts whenever the timer is stopped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= 10'h000;
    end else if (ce) begin
      if (!run) begin
        div_ff <= 10'h000;
      end else begin
        div_ff <= div_ff + 10'h001;
      end
    end
  end
endmodule

// ===== src/tcc_channel.sv
// one compare channel: match detect and waveform state
`timescale 1ns/10ps
module tcc_channel (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  tcc_chan_if.chan  ch
);
  logic wave_ff;
  logic match;

  assign match = (ch.cnt == ch.match_val); // R14
  assign ch.hit = ch.step && match; // R14
  assign ch.wave = wave_ff;

  // effect lands on the cycle after the tick that saw the trigger
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wave_ff <= 1'b0;
    end else if (ce) begin
      unique case (ch.mode)
        tcc_pkg::TCC_WG_TOGGLE: begin
          if (ch.hit) begin
            wave_ff <= ~wave_ff; // R19 R20 R24
          end
        end
        tcc_pkg::TCC_WG_SINGLE: begin
          // match wins over bottom so a zero match stays low
          if (ch.hit) begin
            wave_ff <= 1'b0; // R21 R22
          end else if (ch.step && ch.cnt == tcc_pkg::TCC_RST_ZERO) begin
            wave_ff <= 1'b1; // R21 R22 R24
          end
        end
        default: begin
          wave_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== bench/tcc_timer_assertions.sv
// bound checker of the timer's bus and pin behaviour
`timescale 1ns/10ps
module tcc_timer_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        evt_a,
  input wire logic [2:0]  channel_waveform_output,
  input wire logic [2:0]  channel_output_oe
);
  logic       rd_take;
  logic       wr_take;
  logic       ctlb_dph_ff;
  logic [2:0] exp_oe_ff;

  // --------------------------------
  // bus tracking
  // --------------------------------
  assign rd_take = hsel && htrans[1] && hready && ce && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && ce && hwrite;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctlb_dph_ff <= 1'b0;
    end else if (hready && ce) begin
      ctlb_dph_ff <= wr_take && (haddr[7:0] == tcc_pkg::TCC_OFF_CTRL_B);
    end
  end

  // only toggle (1) and single slope (3) count as waveform modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exp_oe_ff <= 3'h0;
    end else if (ctlb_dph_ff && hready && ce) begin
      exp_oe_ff <= (hwdata[2:0] == 3'h1 || hwdata[2:0] == 3'h3) ? hwdata[6:4] : 3'h0;
    end
  end

  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (wr_take |=> hreadyout) else $error("write stalled");
  a_wait_cause: assert property (!hreadyout |-> $past(rd_take)) else $error("stray wait");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_oe_follow: assert property (ctlb_dph_ff && hready |=>
    ##[0:1] channel_output_oe == exp_oe_ff)
    else $error("enable not following control");
  a_oe_cause: assert property ($changed(channel_output_oe) |->
    $past(ctlb_dph_ff) || $past(ctlb_dph_ff, 2))
    else $error("enable moved alone");
  a_reset_quiet: assert property ($rose(rst_n) |->
    channel_output_oe == 3'h0 && channel_waveform_output == 3'h0 && hreadyout)
    else $error("outputs busy after reset");
endmodule

bind tcc_timer tcc_timer_assertions u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .evt_a(evt_a),
  .channel_waveform_output(channel_waveform_output), .channel_output_oe(channel_output_oe));

// ===== bench/testbench.sv
// self-checking bench for the compare/waveform timer
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        evt_a = 1'b0;
  logic [2:0]  wave;
  logic [2:0]  oe;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h3628;
  int          err_count = 0;
  int          checks = 0;

  assign hready = hreadyout;
  always #20 clk = ~clk;

  tcc_timer dut (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .evt_a(evt_a),
    .channel_waveform_output(wave), .channel_output_oe(oe));

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] step(logic [15:0] c, logic [15:0] p, logic dn);
    if (dn) return (c == 16'h0) ? p : c - 16'h1;
    return (c == p) ? 16'h0 : c + 16'h1;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // outputs only move on rising edges, so the falling edge sees settled values
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      summarize();
    end
    rdat = hrdata;
    @(posedge clk);
  endtask

  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd(string name, logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rdat);
  endtask

  // the event input is synchronised, so each pulse is given room to land
  task automatic evt(int n);
    repeat (n) begin
      evt_a <= 1'b1;
      repeat (2) @(posedge clk);
      evt_a <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    logic [15:0] c;
    logic [15:0] p;
    logic [15:0] m [3];
    logic        dn;
    logic        prev;
    logic [2:0]  w;
    int          n;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("period", tcc_pkg::TCC_OFF_PERIOD, 32'hffff);
    rd("count", tcc_pkg::TCC_OFF_COUNT, 32'h0);
    rd("valid", tcc_pkg::TCC_OFF_CTRL_F, 32'h0);
    bus(1'b1, 8'h40, 32'h1234);
    rd("unmapped", 8'h40, 32'h0);
    bus(1'b1, tcc_pkg::TCC_OFF_PERIOD, 32'h9);
    bus(1'b1, tcc_pkg::TCC_OFF_EVENT_CONTROL_REGISTER, 32'h1);
    bus(1'b1, tcc_pkg::TCC_OFF_CTRL_A, 32'h1);
    for (int i = 0; i < 8; i++) begin
      p = 16'(rnd() % 32'd12);
      c = 16'(rnd() % 32'd16);
      dn = 1'(rnd() & 32'h1);
      n = int'(rnd() % 32'd20);
      bus(1'b1, tcc_pkg::TCC_OFF_PERIOD, {16'h0, p});
      bus(1'b1, tcc_pkg::TCC_OFF_CTRL_E, {31'h0, dn});
      bus(1'b1, tcc_pkg::TCC_OFF_COUNT, {16'h0, c});
      evt(n);
      repeat (n) c = step(c, p, dn);
      rd("count", tcc_pkg::TCC_OFF_COUNT, {16'h0, c});
    end
    bus(1'b1, tcc_pkg::TCC_OFF_CTRL_E, 32'h2);
    bus(1'b1, tcc_pkg::TCC_OFF_PERIOD, 32'h4);
    bus(1'b1, tcc_pkg::TCC_OFF_COUNT, 32'h4);
    bus(1'b1, tcc_pkg::TCC_OFF_PER_SH, 32'h6);
    bus(1'b1, tcc_pkg::TCC_OFF_MSH0 + 8'h4, 32'h2);
    rd("valid", tcc_pkg::TCC_OFF_CTRL_F, 32'h5);
    bus(1'b1, tcc_pkg::TCC_OFF_FLAGS, 32'h71);
    evt(1);
    rd("locked period", tcc_pkg::TCC_OFF_PERIOD, 32'h4);
    rd("wrapped count", tcc_pkg::TCC_OFF_COUNT, 32'h0);
    bus(1'b0, tcc_pkg::TCC_OFF_FLAGS, 32'h0);
    chk("overflow flag", 32'h1, {31'h0, rdat[0]});
    bus(1'b1, tcc_pkg::TCC_OFF_CTRL_E, 32'h0);
    bus(1'b1, tcc_pkg::TCC_OFF_COUNT, 32'h4);
    evt(1);
    rd("period", tcc_pkg::TCC_OFF_PERIOD, 32'h6);
    rd("match1", tcc_pkg::TCC_OFF_MATCH0 + 8'h4, 32'h2);
    rd("valid", tcc_pkg::TCC_OFF_CTRL_F, 32'h0);
    bus(1'b1, tcc_pkg::TCC_OFF_MATCH0, 32'h3);
    rd("match0", tcc_pkg::TCC_OFF_MATCH0, 32'h3);
    bus(1'b1, tcc_pkg::TCC_OFF_FLAGS, 32'h71);
    bus(1'b1, tcc_pkg::TCC_OFF_COUNT, 32'h2);
    evt(2);
    bus(1'b0, tcc_pkg::TCC_OFF_FLAGS, 32'h0);
    chk("match flag", 32'h2, {30'h0, rdat[4], rdat[0]});
    bus(1'b1, tcc_pkg::TCC_OFF_CTRL_B, 32'h73);
    bus(1'b1, tcc_pkg::TCC_OFF_PERIOD, 32'h7);
    bus(1'b1, tcc_pkg::TCC_OFF_MATCH0 + 8'h4, 32'h0);
    bus(1'b1, tcc_pkg::TCC_OFF_MATCH0 + 8'h8, 32'h9);
    bus(1'b1, tcc_pkg::TCC_OFF_COUNT, 32'h0);
    m = '{16'h3, 16'h0, 16'h9};
    c = 16'h0;
    w = 3'h0;
    for (int i = 0; i < 16; i++) begin
      evt(1);
      for (int k = 0; k < 3; k++) w[k] = (c == m[k]) ? 1'b0 : ((c == 16'h0) ? 1'b1 : w[k]);
      c = step(c, 16'h7, 1'b0);
      @(negedge clk);
      if (i >= 8) chk("pwm", {29'h0, w}, {29'h0, wave});
      @(posedge clk);
    end
    bus(1'b1, tcc_pkg::TCC_OFF_MATCH0, 32'h0);
    bus(1'b1, tcc_pkg::TCC_OFF_CTRL_B, 32'h71);
    bus(1'b1, tcc_pkg::TCC_OFF_EVENT_CONTROL_REGISTER, 32'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    prev = wave[0];
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (wave[0] !== prev) n++;
      prev = wave[0];
    end
    chk("toggles", 32'h8, 32'(n));
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    prev = wave[0];
    repeat (3) @(negedge clk);
    chk("frozen", {31'h0, prev}, {31'h0, wave[0]});
    @(posedge clk);
    ce <= 1'b1;
    for (int md = 0; md < 8; md++) begin
      bus(1'b1, tcc_pkg::TCC_OFF_CTRL_B, 32'h50 | 32'(md));
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("enable", (md == 1 || md == 3) ? 32'h5 : 32'h0, {29'h0, oe});
      @(posedge clk);
    end
    summarize();
  end
endmodule
